//--- src/hbd_dw0.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "hbd_regs.svh"
// Behaviour
// - bit 31 is the endpoint number's low bit, written by software
// - bits 30:29 give packets allowed per descriptor execution
// - each packet is at most the max packet length at bits 28:18
// - any whole max packet length fitting the field is accepted
// - bits 17:3 are the total byte count, up to 32 kB minus one
// - device clears valid when done or on a fatal error
module hbd_dw0
   import hbd_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // packet request toward the link engine
   output logic pktReq,
   output hbd_pkt_t pktInfo,
   // packet completion from the link engine (same clock)
   input wire logic pktDone,
   input wire logic [10:0] pktBytes,
   input wire logic fatalErr,
   // interrupt
   output logic irq
);
   hbd_dw0_t dw0;
   hbd_state_t state;
   logic [14:0] xferred;
   logic [1:0] pktCount;
   logic [1:0] status;
   logic [1:0] mask;
   logic fatalSeen;
   logic [14:0] remaining;
   logic [10:0] nextLen;
   logic [14:0] next_xferred;
   logic finishEvt;
   logic fatalEvt;
   logic wrDw0;
   logic [31:0] next_rdata;
   logic zeroDone;

   assign wrDw0 = regWr && (regAddr == `HBD_OFS_DW0);
   assign remaining = dw0.totalByteCount - xferred;
   assign next_xferred = xferred + {4'h0, pktBytes};
   assign fatalEvt = (state != HBD_IDLE) && fatalErr;
   assign zeroDone = (state == HBD_DONE);

   hbd_pkt_len u_len (
      .remaining(remaining),
      .maxLen(dw0.max_packet_length_a),
      .len(nextLen)
   );

   // finish: total reached, or the multiplier's packet budget spent
   always_comb begin
      finishEvt = 1'b0;
      if (state == HBD_WAIT && pktDone) begin
         if (next_xferred >= dw0.totalByteCount) begin
            finishEvt = 1'b1;
         end else if (pktCount == dw0.mult) begin
            finishEvt = 1'b1;
         end
      end
   end

   // descriptor word: software writes, hardware clears valid
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dw0 <= `HBD_DW0_RST;
      end else if (wrDw0) begin
         dw0 <= regWdata;
         dw0.reserved <= 2'h0;
      end else if (finishEvt || fatalEvt || zeroDone) begin
         dw0.valid <= 1'b0;
      end
   end

   // execution sequencer
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= HBD_IDLE;
         xferred <= 15'h0000;
         pktCount <= 2'h0;
         pktReq <= 1'b0;
         pktInfo <= '0;
      end else begin
         pktReq <= 1'b0;
         case (state)
            HBD_IDLE: begin
               // a rewrite of the word this cycle wins; start next cycle
               if (dw0.valid && !wrDw0) begin
                  // counts restart here so the last total stays readable
                  xferred <= 15'h0000;
                  pktCount <= 2'h0;
                  if (dw0.totalByteCount == 15'h0000) begin
                     state <= HBD_DONE;
                  end else begin
                     state <= HBD_PKT;
                  end
               end
            end
            HBD_PKT: begin
               // a fatal error before the request goes out cancels it
               if (fatalEvt) begin
                  state <= HBD_IDLE;
               end else begin
                  pktReq <= 1'b1;
                  pktInfo.endpointLsb <= dw0.endpointLsb;
                  pktInfo.len <= nextLen;
                  pktCount <= pktCount + 2'h1;
                  state <= HBD_WAIT;
               end
            end
            HBD_WAIT: begin
               if (fatalEvt) begin
                  state <= HBD_IDLE;
               end else if (pktDone) begin
                  xferred <= next_xferred;
                  state <= finishEvt ? HBD_IDLE : HBD_PKT;
               end
            end
            HBD_DONE: begin
               state <= HBD_IDLE;
            end
            default: begin
               state <= HBD_IDLE;
            end
         endcase
      end
   end

   // sticky status; a set in the clearing cycle wins
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         status <= 2'h0;
      end else begin
         if (regWr && regAddr == `HBD_OFS_STATUS) begin
            status <= status & ~regWdata[1:0];
         end
         if (finishEvt || zeroDone) begin
            status[`HBD_ST_DONE] <= 1'b1;
         end
         if (fatalEvt) begin
            status[`HBD_ST_FATAL] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mask <= `HBD_MASK_RST;
      end else if (regWr && regAddr == `HBD_OFS_MASK) begin
         mask <= regWdata[1:0];
      end
   end

   // remembers a fatal end until the descriptor is rewritten
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fatalSeen <= 1'b0;
      end else if (wrDw0) begin
         fatalSeen <= 1'b0;
      end else if (fatalEvt) begin
         fatalSeen <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end

   always_comb begin
      case (regAddr)
         `HBD_OFS_DW0: next_rdata = dw0;
         `HBD_OFS_STATUS: next_rdata = {30'h0, status};
         `HBD_OFS_MASK: next_rdata = {30'h0, mask};
         `HBD_OFS_XFER: next_rdata = {17'h0, xferred};
         `HBD_OFS_ERR: next_rdata = {31'h0, fatalSeen};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         regRdata <= next_rdata;
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // assertions
   sequence pktIssued;
      state == HBD_PKT && !fatalErr;
   endsequence

   sequence reqSeen;
      pktReq && pktInfo.len <= $past(dw0.max_packet_length_a);
   endsequence

   sequence startTaken;
      state == HBD_IDLE && dw0.valid && !wrDw0
         && dw0.totalByteCount != 15'h0000;
   endsequence

   sequence reqFollows;
      state == HBD_PKT ##1 (pktReq || !dw0.valid);
   endsequence

   no_idle_start_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      (state == HBD_IDLE && !dw0.valid) |=> state != HBD_PKT)
      else $error("packet started for an invalid descriptor");

   pkt_len_cap_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      pktIssued |=> reqSeen)
      else $error("packet request missing or longer than max length");

   valid_clear_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      (finishEvt && !wrDw0) |=> !dw0.valid)
      else $error("valid not cleared at end of execution");

   fatal_clear_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      (fatalEvt && !wrDw0) |=> !dw0.valid && state == HBD_IDLE)
      else $error("valid not cleared on fatal error");

   mult_budget_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      (state == HBD_WAIT && dw0.mult != 2'h0) |-> pktCount <= dw0.mult)
      else $error("more packets than the multiplier allows");

   total_end_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      (state == HBD_WAIT && pktDone && !fatalErr
       && next_xferred >= dw0.totalByteCount) |=> state == HBD_IDLE)
      else $error("execution did not end at total byte count");

   ep_bit_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      pktReq |-> pktInfo.endpointLsb == $past(dw0.endpointLsb))
      else $error("endpoint bit not carried to packet");

   rsvd_zero_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      wrDw0 |=> dw0.reserved == 2'h0)
      else $error("reserved descriptor bits kept a value");

   total_field_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      wrDw0 |=> dw0.totalByteCount == $past(regWdata[14+3:3]))
      else $error("total byte count not taken from bits 17:3");

   zero_clear_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      (zeroDone && !wrDw0) |=> !dw0.valid)
      else $error("valid not cleared for an empty descriptor");

   req_pulse_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      pktReq |=> !pktReq)
      else $error("packet request longer than one cycle");

   irq_level_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      1'b1 |=> irq == |($past(status) & $past(mask)))
      else $error("interrupt does not follow masked status");

   done_sticky_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      (finishEvt || zeroDone) |=> status[`HBD_ST_DONE])
      else $error("done status not set at end of execution");

   fatal_sticky_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      fatalEvt |=> status[`HBD_ST_FATAL])
      else $error("fatal status not set on fatal error");

   rdata_idle_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      !regRd |=> regRdata == 32'h0000_0000)
      else $error("read data not zero outside a read");

   start_order_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      startTaken |=> reqFollows)
      else $error("valid descriptor did not issue its first packet");

   len_total_a: assert property (
      @(posedge ref_clk) disable iff (srst)
      pktReq |-> pktInfo.len <= $past(remaining))
      else $error("packet longer than the bytes still to move");
endmodule

//--- src/hbd_regs.svh
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH
// register offsets (byte addresses)
`define HBD_OFS_DW0 8'h00
`define HBD_OFS_STATUS 8'h04
`define HBD_OFS_MASK 8'h08
`define HBD_OFS_XFER 8'h0C
`define HBD_OFS_ERR 8'h10
// descriptor field positions
`define HBD_EP0_BIT 31
`define HBD_MULT_HI 30
`define HBD_MULT_LO 29
`define HBD_MPL_HI 28
`define HBD_MPL_LO 18
`define HBD_TBC_HI 17
`define HBD_TBC_LO 3
`define HBD_VALID_BIT 0
// status bit positions
`define HBD_ST_DONE 0
`define HBD_ST_FATAL 1
// reset values
`define HBD_DW0_RST 32'h0000_0000
`define HBD_MASK_RST 2'h0
// bulk packet length ceiling in bytes
`define HBD_BULK_MAX 11'h200
`endif

//--- src/hbd_pkg.sv
package hbd_pkg;
   typedef enum logic [1:0] {
      HBD_IDLE = 2'b00,
      HBD_PKT = 2'b01,
      HBD_WAIT = 2'b10,
      HBD_DONE = 2'b11
   } hbd_state_t;

   typedef struct packed {
      logic endpointLsb;
      logic [1:0] mult;
      logic [10:0] max_packet_length_a;
      logic [14:0] totalByteCount;
      logic [1:0] reserved;
      logic valid;
   } hbd_dw0_t;

   // one packet request toward the link engine
   typedef struct packed {
      logic endpointLsb;
      logic [10:0] len;
   } hbd_pkt_t;
endpackage

//--- src/hbd_pkt_len.sv
`timescale 1ns/1ps
// length of the next packet: the smaller of remaining bytes and max length
module hbd_pkt_len (
   // inputs
   input wire logic [14:0] remaining,
   input wire logic [10:0] maxLen,
   // result
   output logic [10:0] len
);
   always_comb begin
      if (remaining < {4'h0, maxLen}) begin
         len = remaining[10:0];
      end else begin
         len = maxLen;
      end
   end
endmodule

//--- verification/hbd_link_model.sv
`timescale 1ns/1ps
// link engine stand-in: answers each packet after a chosen delay
module hbd_link_model
   import hbd_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // packet side
   input wire logic pktReq,
   input wire hbd_pkt_t pktInfo,
   input wire logic [3:0] delay,
   output logic pktDone,
   output logic [10:0] pktBytes
);
   logic [4:0] cnt;
   logic [10:0] len;
   always_ff @(posedge ref_clk) begin
      pktDone <= 1'b0;
      // byte lines toggle outside the done pulse so stale values never match
      pktBytes <= ~pktBytes;
      if (srst) begin
         cnt <= 5'h00;
         pktBytes <= 11'h2AA;
      end else if (pktReq) begin
         cnt <= {1'b0, delay} + 5'h01;
         len <= pktInfo.len;
      end else if (cnt == 5'h01) begin
         cnt <= 5'h00;
         pktDone <= 1'b1;
         pktBytes <= len;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
   end
endmodule

//--- verification/hbd_dw0_tb_top.sv
`timescale 1ns/1ps
`include "hbd_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
   $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module hbd_dw0_tb_top
   import hbd_pkg::*;
;
   logic ref_clk = 0, srst = 1, regWr = 0, regRd = 0, pktReq, pktDone;
   logic fatalErr = 0, irq, rdPend = 0;
   logic [7:0] regAddr = 0;
   logic [31:0] regWdata = 0, regRdata, seed = 32'd34305;
   logic [31:0] expRd;
   logic [10:0] pktBytes;
   logic [3:0] delay = 0;
   hbd_pkt_t pktInfo, expPk;
   logic [31:0] rdQ[$];
   hbd_pkt_t pkQ[$];
   int mismatches = 0, checked = 0;
   hbd_dw0 dut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .pktReq(pktReq), .pktInfo(pktInfo),
      .pktDone(pktDone), .pktBytes(pktBytes), .fatalErr(fatalErr),
      .irq(irq));
   hbd_link_model far (.ref_clk(ref_clk), .srst(srst), .pktReq(pktReq),
      .pktInfo(pktInfo), .delay(delay), .pktDone(pktDone),
      .pktBytes(pktBytes));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task results();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      rdQ.push_back(e);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
   endtask
   task drain();
      for (int i = 0; i < 300 && pkQ.size() > 0; i++) @(posedge ref_clk);
      if (pkQ.size() > 0) begin
         mismatches++;
         results();
      end
      // the last packet may still take up to 17 cycles to complete
      repeat (24) @(posedge ref_clk);
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge ref_clk) begin
      rdPend <= regRd;
      if (rdPend) begin
         expRd = rdQ.pop_front();
         `CHK(regRdata, expRd)
      end
      if (pktReq && pkQ.size() == 0) begin
         `CHK(pktReq, 1'b0)
      end else if (pktReq) begin
         expPk = pkQ.pop_front();
         `CHK(pktInfo, expPk)
      end
   end
   initial begin : main
      logic [31:0] d;
      logic [14:0] tot, rem, xf;
      logic [10:0] mpl, l;
      logic ep;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      rdQ.delete();
      rd(`HBD_OFS_DW0, 0);
      rd(`HBD_OFS_STATUS, 0);
      rd(`HBD_OFS_MASK, 0);
      rd(`HBD_OFS_XFER, 0);
      rd(8'h14, 0);
      $display("reset values done");
      wr(`HBD_OFS_MASK, 32'h1);
      for (int m = 1; m < 4; m++) begin
         mpl = 11'(xs() % 512) + 11'h001;
         tot = 15'(xs() % 1600) + 15'h0001;
         ep = 1'(xs());
         delay <= 4'(xs());
         // reserved bits written as ones must read back as zero
         d = {ep, 2'(m), mpl, tot, 2'b11, 1'b0};
         wr(`HBD_OFS_DW0, d);
         repeat (8) @(posedge ref_clk);
         rd(`HBD_OFS_DW0, d & 32'hFFFF_FFF9);
         rem = tot;
         xf = 0;
         for (int n = 0; n < m && rem > 0; n++) begin
            l = (rem < 15'(mpl)) ? 11'(rem) : mpl;
            pkQ.push_back({ep, l});
            rem -= 15'(l);
            xf += 15'(l);
         end
         wr(`HBD_OFS_DW0, d | 32'h1);
         drain();
         rd(`HBD_OFS_DW0, d & 32'hFFFF_FFF8);
         rd(`HBD_OFS_XFER, {17'h0, xf});
         rd(`HBD_OFS_STATUS, 32'h1);
         `CHK(irq, 1'b1)
         wr(`HBD_OFS_STATUS, 32'h1);
         repeat (3) @(posedge ref_clk);
         `CHK(irq, 1'b0)
      end
      $display("execution tests done");
      delay <= 4'hF;
      d = {1'b1, 2'h3, 11'h040, 15'h0100, 3'b001};
      pkQ.push_back({1'b1, 11'h040});
      wr(`HBD_OFS_DW0, d);
      for (int i = 0; i < 50 && !pktReq; i++) @(posedge ref_clk);
      if (!pktReq) begin
         mismatches++;
         results();
      end
      fatalErr <= 1'b1;
      @(posedge ref_clk);
      fatalErr <= 1'b0;
      drain();
      rd(`HBD_OFS_DW0, d & 32'hFFFF_FFF8);
      rd(`HBD_OFS_STATUS, 32'h2);
      rd(`HBD_OFS_ERR, 32'h1);
      `CHK(irq, 1'b0)
      repeat (3) @(posedge ref_clk);
      $display("fatal test done");
      // an empty descriptor ends at once, issues no packet, drops valid
      wr(`HBD_OFS_DW0, 32'h2000_0001);
      repeat (4) @(posedge ref_clk);
      rd(`HBD_OFS_DW0, 32'h2000_0000);
      rd(`HBD_OFS_STATUS, 32'h0000_0003);
      rd(`HBD_OFS_ERR, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      $display("empty descriptor test done");
      results();
   end
endmodule
